// ===== common/mfb_consts.svh
// constants for the latched monitor flag bank
// Behaviour
// R1: byte 6 temperature flags, bits 3-1 reserved
// R2: byte 6 bit 0 set after init/reset
// R3: host read clears the init-done bit
// R4: byte 7 supply flags, bits 3-0 reserved
// R5: byte 8 vendor specific, no flags
// R6: bytes 9-10 receive power, channel pairs
// R7: bytes 11-12 transmit bias, channel pairs
// R8: byte 13 transmit power, channels 1-2
// R9: every flag is sticky after condition clears
// R10: flags zero by default, set on condition
// R11: flag holds until read or reset
// R12: byte 14 transmit power, channels 3-4
// R13: compare value against high and low thresholds
`ifndef MFB_CONSTS_SVH
`define MFB_CONSTS_SVH

// two-wire slave address, arbitrary default
`define MFB_DEV_ADDR       7'h50

// register offsets
`define MFB_OFS_TEMP       8'h06
`define MFB_OFS_SUPPLY     8'h07
`define MFB_OFS_VENDOR     8'h08
`define MFB_OFS_RXP12      8'h09
`define MFB_OFS_RXP34      8'h0A
`define MFB_OFS_BIAS12     8'h0B
`define MFB_OFS_BIAS34     8'h0C
`define MFB_OFS_TXP12      8'h0D
`define MFB_OFS_TXP34      8'h0E
`define MFB_NUM_BYTES      9

// field positions and reset values
`define MFB_BIT_INIT_DONE  0
`define MFB_FLAG_RESET     8'h00
`define MFB_RSVD_TEMP      3'h0
`define MFB_RSVD_SUPPLY    4'h0

// monitor slots
`define MFB_NUM_MON        14
`define MFB_MON_TEMP       0
`define MFB_MON_SUPPLY     1
`define MFB_MON_RXP1       2
`define MFB_MON_BIAS1      6
`define MFB_MON_TXP1       10

// timing
`define MFB_CLK_PERIOD_NS  5
`define MFB_INIT_TIME_NS   1000
`define MFB_INIT_CYCLES    ((`MFB_INIT_TIME_NS + `MFB_CLK_PERIOD_NS - 1) / `MFB_CLK_PERIOD_NS)

`endif

// ===== common/mfb_pkg.sv
// types shared by the latched monitor flag bank
package mfb_pkg;

  typedef logic [7:0] mfb_byte_t;

  // one monitored quantity with its four thresholds
  typedef struct packed {
    logic [15:0] value;
    logic [15:0] th_hi_alm;
    logic [15:0] th_lo_alm;
    logic [15:0] th_hi_wrn;
    logic [15:0] th_lo_wrn;
  } mfb_mon_t;

  // flag nibble, most significant first
  typedef struct packed {
    logic hi_alm;
    logic lo_alm;
    logic hi_wrn;
    logic lo_wrn;
  } mfb_nib_t;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_ack,
    st_wr,
    st_rd,
    st_rack
  } mfb_state_t;

endpackage

// ===== verilog/mfb_thresh_cmp.sv
// registered threshold comparator for one monitored value
module mfb_thresh_cmp #(
  parameter bit SIGNED_VAL = 1'b0
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // monitored value with thresholds
  input  mfb_pkg::mfb_mon_t   mon,
  // condition nibble, one cycle behind
  output mfb_pkg::mfb_nib_t   cond
);
  import mfb_pkg::*;

  // temperature is two's complement, the rest unsigned
  function automatic logic above(input logic [15:0] a, input logic [15:0] b);
    if (SIGNED_VAL)
      above = $signed(a) > $signed(b);
    else
      above = a > b;
  endfunction

  // high flags above high threshold, low flags below low threshold
  wire mfb_nib_t next_cond = '{
    hi_alm: above(mon.value, mon.th_hi_alm),  // [R13]
    lo_alm: above(mon.th_lo_alm, mon.value),  // [R13]
    hi_wrn: above(mon.value, mon.th_hi_wrn),  // [R13]
    lo_wrn: above(mon.th_lo_wrn, mon.value)   // [R13]
  };

  // registered so the flag bank sees a clean level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cond <= '0;
    else
      cond <= next_cond;
  end

endmodule

// ===== verilog/mfb_flag_bank.sv
// latched monitor flag bank behind a two-wire management slave
`include "mfb_consts.svh"

module mfb_flag_bank (
  // clock and module reset
  input  wire logic                                 clk,
  input  wire logic                                 resetn,
  // monitored values and thresholds
  input  mfb_pkg::mfb_mon_t [`MFB_NUM_MON-1:0]      mon,
  // two-wire management pins
  input  wire logic                                 scl_i,
  input  wire logic                                 sda_i,
  output logic                                      sda_o,
  output logic                                      sda_oe_n
);
  import mfb_pkg::*;

  // reset release through two flops; assertion stays asynchronous
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // pin synchronisers; q1 feeds only q2
  logic scl_q1;
  logic scl_q2;
  logic scl_q3;
  logic sda_q1;
  logic sda_q2;
  logic sda_q3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_q1, scl_q2, scl_q3} <= 3'h7;
      {sda_q1, sda_q2, sda_q3} <= 3'h7;
    end else begin
      {scl_q1, scl_q2, scl_q3} <= {scl_i, scl_q1, scl_q2};
      {sda_q1, sda_q2, sda_q3} <= {sda_i, sda_q1, sda_q2};
    end
  end

  // bus events from the second and third stages
  wire scl_rise  = scl_q2 & ~scl_q3;
  wire scl_fall  = ~scl_q2 & scl_q3;
  wire sda_s     = sda_q2;
  wire bus_start = scl_q2 & scl_q3 & sda_q3 & ~sda_q2;
  wire bus_stop  = scl_q2 & scl_q3 & ~sda_q3 & sda_q2;

  // one comparator per monitored quantity
  mfb_nib_t cond [`MFB_NUM_MON];

  for (genvar g = 0; g < `MFB_NUM_MON; g++) begin : g_cmp
    mfb_thresh_cmp #(
      .SIGNED_VAL (g == `MFB_MON_TEMP)
    ) u_cmp (
      .clk   (clk),
      .rst_n (rst_n),
      .mon   (mon[g]),
      .cond  (cond[g])
    );
  end

  // init-done timer: one set pulse once the reset sequence has run
  logic [7:0] init_cnt;
  logic       init_done;
  wire        init_pulse = !init_done && (init_cnt == 8'(`MFB_INIT_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt  <= 8'h00;
      init_done <= 1'b0;
    end else begin
      init_cnt  <= init_done ? init_cnt : init_cnt + 8'h01;
      init_done <= init_done | init_pulse;
    end
  end

  // address decode shared by read data and read clear
  function automatic logic in_bank(input logic [7:0] addr);
    in_bank = (addr >= `MFB_OFS_TEMP) && (addr <= `MFB_OFS_TXP34);
  endfunction

  function automatic logic [3:0] bank_idx(input logic [7:0] addr);
    logic [7:0] d;
    d        = addr - `MFB_OFS_TEMP;
    bank_idx = d[3:0];
  endfunction

  // flag storage and per-byte set and clear terms
  mfb_byte_t flag [`MFB_NUM_BYTES];
  mfb_byte_t set  [`MFB_NUM_BYTES];
  mfb_byte_t clr  [`MFB_NUM_BYTES];

  logic       rd_pulse;
  logic [7:0] ptr;

  // byte map of condition nibbles, lower channel in upper nibble
  assign set[0] = {cond[`MFB_MON_TEMP], `MFB_RSVD_TEMP, init_pulse};  // [R1] [R2]
  assign set[1] = {cond[`MFB_MON_SUPPLY], `MFB_RSVD_SUPPLY};           // [R4]
  assign set[2] = `MFB_FLAG_RESET;                                     // [R5]
  for (genvar b = 3; b < `MFB_NUM_BYTES; b++) begin : g_pair
    assign set[b] = {cond[2*b-4], cond[2*b-3]};                        // [R6] [R7] [R8] [R12]
  end

  // a read clears exactly the bits it returned, nothing set later
  for (genvar b = 0; b < `MFB_NUM_BYTES; b++) begin : g_clr
    assign clr[b] = (rd_pulse && in_bank(ptr) && bank_idx(ptr) == 4'(b)) ? flag[b] : `MFB_FLAG_RESET;  // [R3] [R11]
  end

  // sticky latch; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `MFB_NUM_BYTES; i++)
        flag[i] <= `MFB_FLAG_RESET;  // [R10] [R11]
    end else begin
      for (int i = 0; i < `MFB_NUM_BYTES; i++)
        flag[i] <= (flag[i] & ~clr[i]) | set[i];  // [R9] [R11]
    end
  end

  // byte returned to the host; unmapped offsets read zero
  wire mfb_byte_t rd_byte = in_bank(ptr) ? flag[bank_idx(ptr)] : `MFB_FLAG_RESET;

  // two-wire slave state
  mfb_state_t state;
  mfb_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] next_ptr;
  logic       ptr_loaded;
  logic       next_ptr_loaded;
  logic       is_read;
  logic       next_is_read;
  logic       nack;
  logic       next_nack;
  logic       next_drive;
  wire        drive_low = ~sda_oe_n;

  // slave sequencing; data changes only after scl falls
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_shreg      = shreg;
    next_ptr        = ptr;
    next_ptr_loaded = ptr_loaded;
    next_is_read    = is_read;
    next_nack       = nack;
    next_drive      = drive_low;
    rd_pulse        = 1'b0;
    if (bus_start) begin
      next_state      = st_addr;
      next_cnt        = 4'h0;
      next_drive      = 1'b0;
      next_ptr_loaded = 1'b0;
    end else if (bus_stop) begin
      next_state = st_idle;
      next_drive = 1'b0;
    end else begin
      case (state)
        st_idle: begin
          next_drive = 1'b0;
        end
        st_addr: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt   = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            if (shreg[7:1] == `MFB_DEV_ADDR) begin
              next_is_read = shreg[0];
              next_drive   = 1'b1;
              next_state   = st_ack;
            end else begin
              next_state = st_idle;
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (is_read) begin
              rd_pulse   = 1'b1;  // [R3]
              next_shreg = rd_byte;
              next_ptr   = ptr + 8'h01;
              next_drive = ~rd_byte[7];
              next_state = st_rd;
            end else begin
              next_drive = 1'b0;
              next_state = st_wr;
            end
          end
        end
        st_wr: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt   = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            // first byte moves the pointer; flag bytes ignore data
            if (!ptr_loaded) begin
              next_ptr        = shreg;
              next_ptr_loaded = 1'b1;
            end else begin
              next_ptr = ptr + 8'h01;
            end
            next_drive = 1'b1;
            next_state = st_ack;
          end
        end
        st_rd: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == 4'h8) begin
              next_drive = 1'b0;
              next_state = st_rack;
            end else begin
              next_drive = ~shreg[3'h7 - cnt[2:0]];
            end
          end
        end
        st_rack: begin
          if (scl_rise) begin
            next_nack = sda_s;
          end else if (scl_fall) begin
            next_cnt = 4'h0;
            if (nack) begin
              next_state = st_idle;
            end else begin
              rd_pulse   = 1'b1;  // [R3]
              next_shreg = rd_byte;
              next_ptr   = ptr + 8'h01;
              next_drive = ~rd_byte[7];
              next_state = st_rd;
            end
          end
        end
        default: begin
          next_state = st_idle;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  // slave registers; pointer survives stops for current-address reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= st_idle;
      cnt        <= 4'h0;
      shreg      <= 8'h00;
      ptr        <= 8'h00;
      ptr_loaded <= 1'b0;
      is_read    <= 1'b0;
      nack       <= 1'b0;
      sda_oe_n   <= 1'b1;
      sda_o      <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      shreg      <= next_shreg;
      ptr        <= next_ptr;
      ptr_loaded <= next_ptr_loaded;
      is_read    <= next_is_read;
      nack       <= next_nack;
      sda_oe_n   <= ~next_drive;
      sda_o      <= 1'b0;
    end
  end

  // checks on the flag bank
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [8*`MFB_NUM_BYTES-1:0] flag_flat;
  logic [8*`MFB_NUM_BYTES-1:0] set_flat;
  logic [8*`MFB_NUM_BYTES-1:0] clr_flat;
  for (genvar b = 0; b < `MFB_NUM_BYTES; b++) begin : g_flat
    assign flag_flat[8*b +: 8] = flag[b];
    assign set_flat[8*b +: 8]  = set[b];
    assign clr_flat[8*b +: 8]  = clr[b];
  end

  sequence s_init_read;
    rd_pulse && ptr == `MFB_OFS_TEMP && flag[0][`MFB_BIT_INIT_DONE] && !init_pulse;
  endsequence

  a_init_done_set: assert property (init_pulse |=> flag[0][`MFB_BIT_INIT_DONE] [*2])  // [R2]
    else $error("init-done flag not set after init pulse");
  a_init_read_clear: assert property (s_init_read |=> !flag[0][`MFB_BIT_INIT_DONE])  // [R3]
    else $error("init-done flag survived a read");
  a_temp_reserved: assert property (flag[0][3:1] == `MFB_RSVD_TEMP)  // [R1]
    else $error("reserved temperature bits set");
  a_supply_reserved: assert property (flag[1][3:0] == `MFB_RSVD_SUPPLY)  // [R4]
    else $error("reserved supply bits set");
  a_vendor_zero: assert property (flag[2] == `MFB_FLAG_RESET)  // [R5]
    else $error("vendor byte not zero");
  a_flag_sticky: assert property (1'b1 |=> (flag_flat & $past(flag_flat & ~clr_flat)) == $past(flag_flat & ~clr_flat))  // [R9]
    else $error("flag dropped without a read");
  a_flag_cause: assert property ((flag_flat & ~$past(flag_flat) & ~$past(set_flat)) == '0)  // [R10]
    else $error("flag set without a condition");
  a_rx_map: assert property ($rose(cond[`MFB_MON_RXP1].hi_alm) |=> flag[3][7])  // [R6]
    else $error("receive power channel 1 high alarm not latched");
  a_bias_map: assert property (cond[`MFB_MON_BIAS1+3] != 4'h0 |=> (flag[6][3:0] & $past(cond[`MFB_MON_BIAS1+3])) == $past(cond[`MFB_MON_BIAS1+3]))  // [R7]
    else $error("transmit bias channel 4 flags not latched");
  a_txp_low_map: assert property (cond[`MFB_MON_TXP1] != 4'h0 |=> (flag[7][7:4] & $past(cond[`MFB_MON_TXP1])) == $past(cond[`MFB_MON_TXP1]))  // [R8]
    else $error("transmit power channel 1 flags not latched");
  a_txp_high_map: assert property (cond[`MFB_MON_TXP1+3] != 4'h0 |=> (flag[8][3:0] & $past(cond[`MFB_MON_TXP1+3])) == $past(cond[`MFB_MON_TXP1+3]))  // [R12]
    else $error("transmit power channel 4 flags not latched");
  a_read_clear_hold: assert property (rd_pulse && (flag_flat & ~set_flat) != '0 |=> (flag_flat & $past(clr_flat & ~set_flat)) == '0)  // [R11]
    else $error("read did not clear the returned bits");

endmodule

// ===== verification/mfb_host_model.sv
// two-wire host model that reads and writes the flag bank
module mfb_host_model (
  // clock
  input  wire logic clk,
  // two-wire pins, data is open drain with pull-up
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] rx [16];
  logic       addr_ack;

  // bus idles released, link clock stands still high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // 25 clk cycles per bit give the 125 ns link clock
  task automatic bit_xfer(input logic d, output logic q);
    scl <= 1'b0;
    wait_clk(6);
    sda_drv <= d;
    wait_clk(6);
    scl <= 1'b1;
    wait_clk(12);
    q = sda_line;
    wait_clk(1);
  endtask

  // data moves while clock high: 1 then 0 is a start, 0 then 1 a stop
  task automatic frame_edge(input logic d1, input logic d2);
    scl <= 1'b0;
    wait_clk(6);
    sda_drv <= d1;
    wait_clk(6);
    scl <= 1'b1;
    wait_clk(6);
    sda_drv <= d2;
    wait_clk(6);
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], q);
    bit_xfer(1'b1, q);
    ack = !q;
  endtask

  // last byte is answered by releasing the line, the rest acked low
  task automatic recv(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, q);
      b[i] = q;
    end
    bit_xfer(last, q);
  endtask

  // pointer write, repeated start, then n bytes read whole
  task automatic read_block(input logic [6:0] dev, input logic [7:0] ptr, input int n);
    logic a;
    frame_edge(1'b1, 1'b0);
    send({dev, 1'b0}, addr_ack);
    send(ptr, a);
    frame_edge(1'b1, 1'b0);
    send({dev, 1'b1}, a);
    for (int i = 0; i < n; i++) recv(i == n - 1, rx[i]);
    frame_edge(1'b0, 1'b1);
  endtask

  // current-address read: no pointer byte, the slave keeps its pointer
  task automatic read_cur(input logic [6:0] dev, input int n);
    logic a;
    frame_edge(1'b1, 1'b0);
    send({dev, 1'b1}, a);
    for (int i = 0; i < n; i++) recv(i == n - 1, rx[i]);
    frame_edge(1'b0, 1'b1);
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
    logic a;
    frame_edge(1'b1, 1'b0);
    send({dev, 1'b0}, a);
    send(ptr, a);
    send(d, a);
    frame_edge(1'b0, 1'b1);
  endtask
endmodule

// ===== verification/mfb_flag_bank_test.sv
// self-checking bench for the latched monitor flag bank
`include "mfb_consts.svh"
`define CHK(name, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("BAD %s expected %h seen %h", name, exp, got); \
    end \
  end

module mfb_flag_bank_test import mfb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic                        clk;
  logic                        resetn;
  wire logic                   scl;
  wire logic                   sda_drv;
  wire logic                   sda_line;
  logic                        sda_o;
  logic                        sda_oe_n;
  mfb_mon_t [`MFB_NUM_MON-1:0] mon;
  int                          n_mismatch;
  int                          checks;
  int                          cycles;

  // open-drain wire: device pull, host pull, else pull-up
  assign sda_line = (sda_oe_n ? 1'b1 : sda_o) & sda_drv;

  mfb_flag_bank DUT (
    .clk      (clk),
    .resetn   (resetn),
    .mon      (mon),
    .scl_i    (scl),
    .sda_i    (sda_line),
    .sda_o    (sda_o),
    .sda_oe_n (sda_oe_n)
  );

  mfb_host_model host (
    .clk      (clk),
    .scl      (scl),
    .sda_drv  (sda_drv),
    .sda_line (sda_line)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a whole run needs about 27000 cycles, so a hang is cut at 60000
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // even slots go above both high limits, odd slots below both low ones
  task automatic set_mon(input bit active);
    for (int s = 0; s < `MFB_NUM_MON; s++) begin
      mon[s] <= '{value: !active ? 16'h1000 : (s % 2 == 0) ? 16'h5000 : 16'h0010,
                 th_hi_alm: 16'h4000, th_lo_alm: 16'h0100, th_hi_wrn: 16'h3000, th_lo_wrn: 16'h0200};
    end
  endtask

  // reads 0x06..0x0E in one burst; latched image is 1010 / 0101 per slot pair
  task automatic check_all(input bit latched, input bit init);
    mfb_byte_t e;
    e = latched ? 8'hA5 : 8'h00;
    host.read_block(`MFB_DEV_ADDR, `MFB_OFS_TEMP, `MFB_NUM_BYTES);
    `CHK("address ack", 1'b1, host.addr_ack)
    `CHK("temperature flags", {e[7:4], 3'h0, init}, host.rx[0])
    `CHK("supply flags", {e[3:0], 4'h0}, host.rx[1])
    `CHK("vendor byte", 8'h00, host.rx[2])
    for (int i = 3; i < 9; i++) `CHK("channel flags", e, host.rx[i])
  endtask

  task automatic pulse_mon();
    set_mon(1'b1);
    repeat (10) @(posedge clk);
    set_mon(1'b0);
    repeat (10) @(posedge clk);
  endtask

  initial begin
    resetn = 1'b0;
    n_mismatch = 0;
    checks = 0;
    set_mon(1'b0);
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    // init counter runs 200 cycles after release
    repeat (300) @(posedge clk);
    check_all(1'b0, 1'b1);
    check_all(1'b0, 1'b0);
    // condition held across two reads re-sets the flags each time
    set_mon(1'b1);
    repeat (10) @(posedge clk);
    check_all(1'b1, 1'b0);
    check_all(1'b1, 1'b0);
    set_mon(1'b0);
    repeat (10) @(posedge clk);
    // a host write must not clear anything
    host.write_reg(`MFB_DEV_ADDR, `MFB_OFS_RXP12, 8'h00);
    check_all(1'b1, 1'b0);
    check_all(1'b0, 1'b0);
    // module reset drops latched flags and restarts init
    pulse_mon();
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (300) @(posedge clk);
    check_all(1'b0, 1'b1);
    // foreign address is ignored, line stays at pull-up
    host.read_block(7'h51, `MFB_OFS_TEMP, 1);
    `CHK("foreign ack", 1'b0, host.addr_ack)
    `CHK("foreign data", 8'hFF, host.rx[0])
    pulse_mon();
    host.read_block(`MFB_DEV_ADDR, 8'h20, 1);
    `CHK("unmapped byte", 8'h00, host.rx[0])
    check_all(1'b1, 1'b0);
    // a data write still moves the pointer, so a bare read lands on byte 0x0E
    pulse_mon();
    host.write_reg(`MFB_DEV_ADDR, `MFB_OFS_TXP12, 8'h00);
    host.read_cur(`MFB_DEV_ADDR, 1);
    `CHK("current address byte", 8'hA5, host.rx[0])
    complete_run();
  end
endmodule
